// File: arc_fault_stage.sv
// Arc fault stage: zone trip/block decision, status, events, log
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - Block input is sampled once per program cycle and used all cycle.
// - Zone pick-up rising with block inactive sets the zone trip flag.
// - Zone pick-up rising with block active sets only the blocked flag.
// - A live condition word holds trip and blocked per zone.
// - Live sensor status flags cover currents, channels, input, faults.
// - Each flag edge emits an ON or OFF event carrying a time stamp; edges while one is pending merge into it.
// - Events exist in ON and OFF form for every monitored flag.
// - Per-event selections decide which polarities enter the buffer.
// - A cumulative event counter counts events and can be cleared.
// - The last twelve operation records are kept, oldest dropped.
// - A record holds time, event, four currents, sensors and group.
// - Trip, blocked and status outputs go to pins and user logic.
// - Light or pressure trips a zone only where enabled for it.
// - Digital input trips alone in light mode, with a sensor in current mode, never in off mode.
// - Sensor count unlike its configured count flags a fault.
module arc_fault_stage
    import arc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF // Clocks per millisecond
) (
    input wire logic clk_i,                  // 100 MHz clock
    input wire logic sys_rst_i,              // Async reset, high
    input wire logic [7:0] avs_address_i,    // Byte address
    input wire logic avs_read_i,             // Read request
    input wire logic avs_write_i,            // Write request
    input wire logic [31:0] avs_writedata_i, // Write data
    output logic [31:0] avs_readdata_o,      // Read data
    output logic avs_waitrequest_o,          // Stall
    input wire logic block_i,                // From blocking matrix
    input wire logic ph_blk_i,               // Phase current blocked
    input wire logic ph_start_i,             // Phase current start
    input wire logic res_blk_i,              // Residual blocked
    input wire logic res_start_i,            // Residual start
    input wire logic [3:0] light_pin_i,      // Channel light pins
    input wire logic [3:0] pres_pin_i,       // Channel pressure pins
    input wire logic di_pin_i,               // Digital input pin
    input wire logic io_fault_pin_i,         // I/O unit fault pin
    input wire logic [11:0] det_count_i,     // Sensors seen, 3b/chan
    input wire logic [15:0] cur_a_i,         // Phase A current
    input wire logic [15:0] cur_b_i,         // Phase B current
    input wire logic [15:0] cur_c_i,         // Phase C current
    input wire logic [15:0] cur_n_i,         // Residual current
    input wire logic [2:0] sg_i,             // Setting group in use
    output logic [3:0] zone_trip_o,          // Zone trip flags
    output logic [3:0] zone_blocked_o,       // Zone blocked flags
    output logic [EV_N-1:0] status_o,        // Condition and sensors
    output logic evt_valid_o,                // Event generated
    output logic evt_store_o,                // Event goes to buffer
    output logic [4:0] evt_code_o,           // Flag index
    output logic evt_on_o,                   // ON=1, OFF=0
    output logic [31:0] evt_stamp_o,         // Millisecond stamp
    output logic irq_o                       // Level interrupt
);

    // ========================================================
    // Zone pick-up from enables and sensed conditions
    function automatic logic zone_pickup(
        input logic [3:0] len, input logic [3:0] pen,
        input logic [3:0] lit, input logic [3:0] prs,
        input logic phe, input logic rse, input logic di,
        input logic [1:0] mode, input logic ph, input logic rs);
        logic hit;
        logic cur_ok;
        logic dih;
        hit = |(len & lit) | |(pen & prs);
        cur_ok = !(phe | rse) | (phe & ph) | (rse & rs);
        dih = (mode == DI_LIGHT_IN) & di;
        // Current-in mode: a sensor alone is not enough, DI must agree
        return cur_ok & ((mode == DI_CURRENT_IN) ? (di & hit) : (hit | dih));
    endfunction : zone_pickup

    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic [16:0] ms_cnt_q;
    logic tick_q;
    logic [31:0] time_q;
    logic blk_q;
    logic [3:0] pick_prev_q;
    logic [3:0] trip_q;
    logic [3:0] blkd_q;
    logic [EV_N-1:0] mon_prev_q;
    logic [EV_N-1:0] pend_q;
    logic [31:0] evt_cnt_q;
    logic [11:0] zone_en_q;
    logic [15:0] light_en_q;
    logic [15:0] pres_en_q;
    logic [7:0] di_mode_q;
    logic [11:0] ch_cfg_q;
    logic [EV_N-1:0] on_sel_q;
    logic [EV_N-1:0] off_sel_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [3:0] log_idx_q;
    logic ack_q;
    logic [31:0] rdata_q;

    // ========================================================
    // Pins cross in through two flops before use
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
        end else begin
            sync1_q <= {io_fault_pin_i, di_pin_i, pres_pin_i,
                        light_pin_i};
            sync2_q <= sync1_q;
        end
    end

    logic [3:0] light_w;
    logic [3:0] pres_w;
    logic di_w;
    logic io_flt_w;
    assign light_w = sync2_q[3:0];
    assign pres_w = sync2_q[7:4];
    assign di_w = sync2_q[8];
    assign io_flt_w = sync2_q[9];

    // ========================================================
    // Millisecond tick starts each program cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ms_cnt_q <= 17'h00000;
            tick_q <= 1'b0;
            time_q <= RST_ZERO;
        end else begin
            tick_q <= (ms_cnt_q == 17'(MS_CYCLES - 2)); // Period MS_CYCLES
            ms_cnt_q <= tick_q ? 17'h00000 : ms_cnt_q + 17'h00001;
            if (tick_q)
                time_q <= time_q + 32'h0000_0001;
        end
    end

    // ========================================================
    // Zone pick-up, gated by zone enable
    logic [3:0] pick_w;
    logic [3:0] rise_w;
    for (genvar z = 0; z < ZONES; z++) begin : g_zone
        assign pick_w[z] = zone_en_q[z] & zone_pickup(
            light_en_q[4*z +: 4], pres_en_q[4*z +: 4], light_w,
            pres_w, zone_en_q[4+z], zone_en_q[8+z], di_w,
            di_mode_q[2*z +: 2], ph_start_i, res_start_i);
    end
    assign rise_w = pick_w & ~pick_prev_q;

    // Decisions run only on the cycle tick, using the block sampled one tick earlier
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            blk_q <= 1'b0;
            pick_prev_q <= 4'h0;
            trip_q <= 4'h0;
            blkd_q <= 4'h0;
        end else if (tick_q) begin
            blk_q <= block_i;
            pick_prev_q <= pick_w;
            trip_q <= (trip_q | (blk_q ? 4'h0 : rise_w))
                      & pick_w;
            blkd_q <= (blkd_q | (blk_q ? rise_w : 4'h0))
                      & pick_w;
        end
    end

    // ========================================================
    // Live status: condition word and sensor flags
    logic [3:0] sflt_w;
    logic [7:0] cond_w;
    logic [EV_N-1:0] mon_w;
    for (genvar c = 0; c < CHANS; c++) begin : g_chan
        assign sflt_w[c] = det_count_i[3*c +: 3]
                           != ch_cfg_q[3*c +: 3];
        assign cond_w[2*c +: 2] = {blkd_q[c], trip_q[c]};
    end
    assign mon_w = {io_flt_w, sflt_w, di_w, pres_w, light_w,
                    res_start_i, res_blk_i, ph_start_i, ph_blk_i,
                    cond_w};
    assign status_o = mon_w;
    assign zone_trip_o = trip_q;
    assign zone_blocked_o = blkd_q;

    // ========================================================
    // Event queue: one flag edge is issued per clock, lowest first.
    // A flag that toggles twice before issue reports its final level.
    logic [EV_N-1:0] chg_w;
    logic [EV_N-1:0] grant_w;
    logic [4:0] gidx_w;
    logic gval_w;
    assign chg_w = mon_w ^ mon_prev_q;
    assign grant_w = pend_q & (~pend_q + 26'h000_0001);
    assign gval_w = |pend_q;
    always_comb begin
        gidx_w = 5'h00;
        for (int i = EV_N - 1; i >= 0; i--) begin
            if (pend_q[i])
                gidx_w = 5'(i);
        end
    end

    logic cnt_clr_w;
    logic g_on_w;
    logic trip_on_w;
    assign g_on_w = mon_prev_q[gidx_w];
    assign trip_on_w = gval_w & g_on_w & (gidx_w < 5'd8)
                       & ~gidx_w[0];

    // New changes are ORed after the grant clear, so none is lost
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mon_prev_q <= '0;
            pend_q <= '0;
            evt_valid_o <= 1'b0;
            evt_store_o <= 1'b0;
            evt_code_o <= 5'h00;
            evt_on_o <= 1'b0;
            evt_stamp_o <= RST_ZERO;
        end else begin
            mon_prev_q <= mon_w;
            pend_q <= (pend_q & ~grant_w) | chg_w;
            evt_valid_o <= gval_w;
            evt_store_o <= gval_w & (g_on_w ? on_sel_q[gidx_w]
                                     : off_sel_q[gidx_w]);
            evt_code_o <= gidx_w;
            evt_on_o <= g_on_w;
            evt_stamp_o <= time_q;
        end
    end

    // Counter clear loses to nothing: a clear resets to zero
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            evt_cnt_q <= RST_ZERO;
        else if (cnt_clr_w)
            evt_cnt_q <= RST_ZERO;
        else if (evt_valid_o)
            evt_cnt_q <= evt_cnt_q + 32'h0000_0001;
    end

    // ========================================================
    // Operation log: one record per zone trip ON
    logic [REC_W-1:0] rec_w;
    logic [REC_W-1:0] rd_rec_w;
    logic [3:0] log_cnt_w;
    // Records come only from ON events, so no polarity bit is kept
    assign rec_w = {cur_n_i, cur_c_i, cur_b_i, cur_a_i, sg_i,
                    pres_w, light_w, gidx_w, time_q};

    arc_event_log u_log (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(trip_on_w),
        .rec_i(rec_w),
        .rd_idx_i(log_idx_q),
        .rd_rec_o(rd_rec_w),
        .count_o(log_cnt_w)
    );

    // ========================================================
    // Avalon slave: one wait state, then the answer
    logic acc_w;
    logic wr_w;
    logic [3:0] irq_ev_w;
    assign acc_w = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = acc_w & ~ack_q;
    assign avs_readdata_o = rdata_q;
    assign wr_w = avs_write_i & ack_q;
    assign cnt_clr_w = wr_w & (avs_address_i == OFS_CTRL)
                       & avs_writedata_i[CTRL_CNT_CLR];
    assign irq_ev_w = {trip_on_w, |(sflt_w & ~mon_prev_q[24:21]),
                       |(rise_w & {4{tick_q & blk_q}}),
                       |(rise_w & {4{tick_q & ~blk_q}})};
    assign irq_o = |(irq_stat_q & irq_mask_q);

    logic [31:0] rd_mux_w;
    always_comb begin
        case (avs_address_i)
            OFS_ZONE_EN: rd_mux_w = {20'h00000, zone_en_q};
            OFS_LIGHT_EN: rd_mux_w = {16'h0000, light_en_q};
            OFS_PRES_EN: rd_mux_w = {16'h0000, pres_en_q};
            OFS_DI_MODE: rd_mux_w = {24'h000000, di_mode_q};
            OFS_CH_CFG: rd_mux_w = {20'h00000, ch_cfg_q};
            OFS_ON_SEL: rd_mux_w = {6'h00, on_sel_q};
            OFS_OFF_SEL: rd_mux_w = {6'h00, off_sel_q};
            OFS_STATUS: rd_mux_w = {6'h00, mon_w};
            OFS_EVT_CNT: rd_mux_w = evt_cnt_q;
            OFS_IRQ_STAT: rd_mux_w = {28'h0000000, irq_stat_q};
            OFS_IRQ_MASK: rd_mux_w = {28'h0000000, irq_mask_q};
            OFS_LOG_SEL: rd_mux_w = {24'h000000, log_cnt_w, log_idx_q};
            OFS_LOG_TIME: rd_mux_w = rd_rec_w[31:0];
            OFS_LOG_INFO: rd_mux_w = {16'h0000, rd_rec_w[47:32]};
            OFS_LOG_IAB: rd_mux_w = rd_rec_w[79:48];
            OFS_LOG_ICN: rd_mux_w = rd_rec_w[111:80];
            OFS_TIME_NOW: rd_mux_w = time_q;
            default: rd_mux_w = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= RST_ZERO;
        end else begin
            ack_q <= acc_w & ~ack_q;
            if (avs_read_i & ~ack_q)
                rdata_q <= rd_mux_w;
        end
    end

    // Configuration writes land on the acknowledging edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            zone_en_q <= 12'h000;
            light_en_q <= 16'h0000;
            pres_en_q <= 16'h0000;
            di_mode_q <= 8'h00;
            ch_cfg_q <= 12'h000;
            on_sel_q <= RST_SEL;
            off_sel_q <= RST_SEL;
            irq_mask_q <= 4'h0;
            log_idx_q <= 4'h0;
        end else if (wr_w) begin
            case (avs_address_i)
                OFS_ZONE_EN: zone_en_q <= avs_writedata_i[11:0];
                OFS_LIGHT_EN: light_en_q <= avs_writedata_i[15:0];
                OFS_PRES_EN: pres_en_q <= avs_writedata_i[15:0];
                OFS_DI_MODE: di_mode_q <= avs_writedata_i[7:0];
                OFS_CH_CFG: ch_cfg_q <= avs_writedata_i[11:0];
                OFS_ON_SEL: on_sel_q <= avs_writedata_i[25:0];
                OFS_OFF_SEL: off_sel_q <= avs_writedata_i[25:0];
                OFS_IRQ_MASK: irq_mask_q <= avs_writedata_i[3:0];
                OFS_LOG_SEL: log_idx_q <= avs_writedata_i[3:0];
                default: ;
            endcase
        end
    end

    // Sticky status: a new event in the clear cycle stays set
    logic [3:0] w1c_w;
    assign w1c_w = (wr_w && avs_address_i == OFS_IRQ_STAT)
                   ? avs_writedata_i[3:0] : 4'h0;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            irq_stat_q <= 4'h0;
        else
            irq_stat_q <= (irq_stat_q & ~w1c_w) | irq_ev_w;
    end

    // ========================================================
    // Checks
    a_block_sample: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        tick_q |=> blk_q == $past(block_i))
        else $error("block not sampled at cycle start");
    a_trip_on_rise: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        tick_q && !blk_q && |rise_w |=> (trip_q & $past(rise_w))
            == $past(rise_w) && !(|(blkd_q & $past(rise_w))))
        else $error("unblocked pick-up did not trip");
    a_blocked_no_trip: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        tick_q && blk_q && |rise_w |=> (blkd_q & $past(rise_w))
            == $past(rise_w) && !(|(trip_q & $past(rise_w))))
        else $error("blocked pick-up tripped");
    a_flag_release: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        tick_q |=> ((trip_q | blkd_q) & ~$past(pick_w)) == 4'h0)
        else $error("flag held after pick-up cleared");
    a_event_issue: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        gval_w |=> evt_valid_o && evt_code_o == $past(gidx_w)
            && evt_stamp_o == $past(time_q))
        else $error("pending change not issued");
    a_store_select: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        evt_valid_o && $stable(on_sel_q) && $stable(off_sel_q) |->
            evt_store_o == (evt_on_o
            ? on_sel_q[evt_code_o] : off_sel_q[evt_code_o]))
        else $error("store flag ignores selection");
    a_count_step: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        evt_valid_o && !cnt_clr_w |=>
            evt_cnt_q == $past(evt_cnt_q) + 32'h0000_0001)
        else $error("event counter did not step");
    a_bus_answer: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        acc_w && !ack_q |=> !avs_waitrequest_o)
        else $error("bus answer late");
    c_trip: cover property (@(posedge clk_i) tick_q && !blk_q && |rise_w);
    c_block: cover property (@(posedge clk_i) tick_q && blk_q && |rise_w);
    c_log_full: cover property (@(posedge clk_i)
        trip_on_w && log_cnt_w == 4'(LOG_DEPTH));

endmodule : arc_fault_stage

// File: arc_pkg.sv
// Constants and types shared by the arc fault stage and its record log
package arc_pkg;

    // ========================================================
    // Sizes
    localparam int ZONES = 4;
    localparam int CHANS = 4;
    localparam int EV_N = 26;          // Monitored status flags
    localparam int LOG_DEPTH = 12;     // Operation records kept
    localparam int REC_W = 112;        // Record width in bits

    // ========================================================
    // Timing: program cycle is one millisecond tick
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_TIME_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ZONE_EN = 8'h04;
    localparam logic [7:0] OFS_LIGHT_EN = 8'h08;
    localparam logic [7:0] OFS_PRES_EN = 8'h0c;
    localparam logic [7:0] OFS_DI_MODE = 8'h10;
    localparam logic [7:0] OFS_CH_CFG = 8'h14;
    localparam logic [7:0] OFS_ON_SEL = 8'h18;
    localparam logic [7:0] OFS_OFF_SEL = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_EVT_CNT = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFS_LOG_SEL = 8'h30;
    localparam logic [7:0] OFS_LOG_TIME = 8'h34;
    localparam logic [7:0] OFS_LOG_INFO = 8'h38;
    localparam logic [7:0] OFS_LOG_IAB = 8'h3c;
    localparam logic [7:0] OFS_LOG_ICN = 8'h40;
    localparam logic [7:0] OFS_TIME_NOW = 8'h44;

    // ========================================================
    // Field positions
    localparam int CTRL_CNT_CLR = 0;
    localparam int MON_PH_BLK = 8;
    localparam int MON_LIGHT = 12;
    localparam int MON_PRES = 16;
    localparam int MON_DI = 20;
    localparam int MON_SFLT = 21;
    localparam int MON_IOFLT = 25;
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_BLOCK = 1;
    localparam int IRQ_CFG = 2;
    localparam int IRQ_LOG = 3;

    // ========================================================
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [25:0] RST_SEL = 26'h3ff_ffff;

    // Digital input mode per zone
    typedef enum logic [1:0] {
        DI_OFF,
        DI_LIGHT_IN,
        DI_CURRENT_IN
    } di_mode_t;

endpackage : arc_pkg

// File: arc_event_log.sv
// Rolling log of the latest operation records
`timescale 1ns/10ps
module arc_event_log
    import arc_pkg::*;
(
    input wire logic clk_i,                 // System clock
    input wire logic sys_rst_i,             // Async reset, high
    input wire logic wr_i,                  // Store one record
    input wire logic [REC_W-1:0] rec_i,     // Record to store
    input wire logic [3:0] rd_idx_i,        // 0 selects newest
    output logic [REC_W-1:0] rd_rec_o,      // Selected record
    output logic [3:0] count_o              // Records held
);

    logic [REC_W-1:0] mem_q [LOG_DEPTH];
    logic [3:0] wp_q;
    logic [3:0] cnt_q;
    logic [4:0] back_w;
    logic [3:0] rd_addr_w;

    // ========================================================
    // Newest-first read address, wrapping below zero
    assign back_w = {1'b0, wp_q} + 5'(LOG_DEPTH) - 5'd1
                    - {1'b0, rd_idx_i};
    assign rd_addr_w = (back_w >= 5'(LOG_DEPTH))
                       ? 4'(back_w - 5'(LOG_DEPTH)) : back_w[3:0];
    assign count_o = cnt_q;

    // Pointer wraps, so oldest record is overwritten when full
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wp_q <= 4'h0;
            cnt_q <= 4'h0;
        end else if (wr_i) begin
            wp_q <= (wp_q == 4'(LOG_DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
            if (cnt_q != 4'(LOG_DEPTH))
                cnt_q <= cnt_q + 4'h1;
        end
    end

    // Storage has no reset; unwritten slots are never shown
    always_ff @(posedge clk_i) begin
        if (wr_i)
            mem_q[wp_q] <= rec_i;
        rd_rec_o <= (rd_idx_i < cnt_q) ? mem_q[rd_addr_w] : '0;
    end

    a_log_full_hold: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_i && cnt_q == 4'(LOG_DEPTH) |=> cnt_q == 4'(LOG_DEPTH))
        else $error("log count left full state");

endmodule : arc_event_log

// File: arc_far_side.sv
// Far side model: blocking matrix and sensor channel pins
`timescale 1ns/10ps
module arc_far_side (
    input wire logic clk_i,           // System clock
    input wire logic blk_req_i,       // Wanted block level
    input wire logic [3:0] lit_req_i, // Wanted light levels
    output logic block_o,             // To block input
    output logic [3:0] light_o,       // To light pins
    output logic [3:0] pres_o,        // To pressure pins
    output logic di_o,                // To digital input
    output logic [11:0] det_o         // Sensors detected
);
    // ==================================================
    // Levels move just after an edge, as an upstream register would
    always_ff @(posedge clk_i) begin
        block_o <= blk_req_i;
        light_o <= lit_req_i;
    end
    // No pressure sensors, no input, count matches zero configured
    assign pres_o = 4'h0;
    assign di_o = 1'b0;
    assign det_o = 12'h000;
endmodule : arc_far_side

// File: arc_fault_stage_tb.sv
// Testbench: zone trip and block, events, counter, log, interrupt
`timescale 1ns/10ps
module arc_fault_stage_tb;
    import arc_pkg::*;
    localparam int MS = 20;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, rd_q = 1'b0, wr_q = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q, ev_t, stamp = 32'h0;
    logic blk = 1'b0, wreq, block, dip, irq, on_st = 1'b0, off_st = 1'b0;
    logic [3:0] lit = 4'h0, light, pres, trip, blkd;
    logic [11:0] det;
    logic [15:0] cur = 16'h0123;
    logic [2:0] sg = 3'h2;
    logic lvl = 1'b0, ev_v, ev_s, ev_on;
    logic [EV_N-1:0] stat;
    logic [4:0] ev_c;
    int err_count = 0, tests_run = 0, cyc = 0;
    // ==================================================
    // Clock and instances
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    arc_far_side i_arc_far_side (.clk_i(clk_i), .blk_req_i(blk),
        .lit_req_i(lit), .block_o(block), .light_o(light), .pres_o(pres),
        .di_o(dip), .det_o(det));
    arc_fault_stage #(.MS_CYCLES(MS)) i_arc_fault_stage (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd_q),
        .avs_write_i(wr_q), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .block_i(block), .ph_blk_i(lvl),
        .ph_start_i(lvl), .res_blk_i(lvl), .res_start_i(lvl),
        .light_pin_i(light), .pres_pin_i(pres), .di_pin_i(dip),
        .io_fault_pin_i(lvl), .det_count_i(det), .cur_a_i(cur),
        .cur_b_i(cur), .cur_c_i(cur), .cur_n_i(cur), .sg_i(sg),
        .zone_trip_o(trip), .zone_blocked_o(blkd), .status_o(stat),
        .evt_valid_o(ev_v), .evt_store_o(ev_s), .evt_code_o(ev_c),
        .evt_on_o(ev_on), .evt_stamp_o(ev_t), .irq_o(irq));
    // ==================================================
    // Verdict, compare and bus tasks
    task summarize;
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is seen low at an edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        wr_q <= w;
        rd_q <= !w;
        @(posedge clk_i);
        while (wreq !== 1'b0) @(posedge clk_i);
        q = rdat;
        rd_q <= 1'b0;
        wr_q <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    // Bounded wait for one status flag, then compare it
    task wait_bit(input int b, input logic v);
        int n;
        n = 0;
        while (stat[b] !== v && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, stat[b]}, {31'h0, v});
    endtask : wait_bit
    // ==================================================
    // Event watcher and hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
        if (ev_v === 1'b1 && ev_on === 1'b1 && ev_c === 5'h0c) on_st <= ev_s;
        if (ev_v === 1'b1 && ev_on === 1'b0) off_st <= off_st | ev_s;
        if (ev_v === 1'b1 && ev_on === 1'b1 && ev_c === 5'h00) stamp <= ev_t;
    end
    // ==================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(OFS_ON_SEL, 32'h03ff_ffff);
        rd(OFS_EVT_CNT, 32'h0);
        rd(8'hfc, 32'h0);
        wr(OFS_ZONE_EN, 32'h1);
        wr(OFS_LIGHT_EN, 32'h1);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_OFF_SEL, 32'h0);
        lit <= 4'h1;
        wait_bit(0, 1'b1);
        chk({28'h0, trip}, 32'h1);
        chk({28'h0, blkd}, 32'h0);
        repeat (4) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_LOG_SEL, 32'h0);
        repeat (2) @(posedge clk_i);
        rd(OFS_LOG_SEL, 32'h10);
        rd(OFS_LOG_INFO, 32'h4020);
        rd(OFS_LOG_TIME, stamp);
        rd(OFS_LOG_IAB, 32'h0123_0123);
        lit <= 4'h0;
        wait_bit(0, 1'b0);
        repeat (4) @(posedge clk_i);
        rd(OFS_EVT_CNT, 32'h4);
        chk({30'h0, on_st, off_st}, 32'h2);
        wr(OFS_IRQ_STAT, 32'hf);
        chk({31'h0, irq}, 32'h0);
        // Block raised two program cycles ahead of the pick-up
        blk <= 1'b1;
        repeat (2 * MS) @(posedge clk_i);
        lit <= 4'h1;
        wait_bit(1, 1'b1);
        chk({28'h0, trip}, 32'h0);
        repeat (4) @(posedge clk_i);
        rd(OFS_IRQ_STAT, 32'h2);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_EVT_CNT, 32'h0);
        // Current-in mode with the input idle drops the pick-up
        wr(OFS_DI_MODE, 32'h2);
        wait_bit(1, 1'b0);
        wr(OFS_CH_CFG, 32'h1);
        wait_bit(21, 1'b1);
        rd(OFS_IRQ_STAT, 32'h6);
        summarize();
    end
endmodule : arc_fault_stage_tb
